// file: bench/testbench.sv
// Self-checking bench for the MAC statistics counters over AXI4-Lite
`define CHECK(name, exp, got) begin n_compared++; if ((got) !== (exp)) begin n_errors++; \
 $display("mismatch %s expected %h seen %h", name, exp, got); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [11:0] TX64 = mac_stats_pkg::TX_CNT_BASE_IDX + mac_stats_pkg::CNT_64B_OFF;
   localparam logic [11:0] TX65 = mac_stats_pkg::TX_CNT_BASE_IDX + mac_stats_pkg::CNT_65TO127B_OFF;
   localparam logic [11:0] TXFR = mac_stats_pkg::TX_CNT_BASE_IDX + mac_stats_pkg::CNT_FRAG_OFF;
   localparam logic [11:0] TXCE = mac_stats_pkg::TX_CNT_BASE_IDX + mac_stats_pkg::CNT_CRCERR_OFF;
   localparam logic [11:0] RX64 = mac_stats_pkg::RX_CNT_BASE_IDX + mac_stats_pkg::CNT_64B_OFF;
   logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
   logic [15:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf, tx_stats_inc, rx_stats_inc;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, tx_error_inject = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, wr_resp, rd_resp;
   logic [31:0] rd_data, off_rdata;
   mac_stats_pkg::stats_event_s tx_event = '0, rx_event = '0;
   int n_errors = 0, n_compared = 0;

   mac_statistics_counters mac_statistics_counters_i (.aclk(aclk), .aresetn(aresetn), .ce(ce),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .tx_event(tx_event),
      .tx_error_inject(tx_error_inject), .rx_event(rx_event), .tx_stats_inc(tx_stats_inc),
      .rx_stats_inc(rx_stats_inc));

   // Same stimulus into a build without counters, which reads them as zero
   mac_statistics_counters #(.stats_enable(1'b0)) mac_statistics_counters_off_i (.aclk(aclk),
      .aresetn(aresetn), .ce(ce), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(), .s_axi_rdata(off_rdata), .s_axi_rresp(), .s_axi_rvalid(),
      .s_axi_rready(s_axi_rready), .tx_event(tx_event), .tx_error_inject(tx_error_inject),
      .rx_event(rx_event), .tx_stats_inc(), .rx_stats_inc());

   initial begin
      forever #12.5 aclk = ~aclk;
   end

   //--------------------------------------------------------------------------
   // Bus tasks
   //--------------------------------------------------------------------------
   // Handshakes are decided just after an edge, so they hold for the next sampling edge
   task automatic axi_write(input logic [11:0] idx, input logic [31:0] data);
      logic aw_hs, w_hs;
      @(posedge aclk);
      s_axi_awaddr <= {2'b00, idx, 2'b00};
      s_axi_wdata <= data;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         #1;
         if (s_axi_bvalid === 1'b1) begin
            wr_resp = s_axi_bresp;
            @(posedge aclk);
            s_axi_bready <= 1'b0;
            break;
         end
         aw_hs = s_axi_awvalid && s_axi_awready;
         w_hs = s_axi_wvalid && s_axi_wready;
         @(posedge aclk);
         if (aw_hs) s_axi_awvalid <= 1'b0;
         if (w_hs) s_axi_wvalid <= 1'b0;
      end
   endtask : axi_write

   task automatic axi_read(input logic [11:0] idx);
      logic ar_hs;
      @(posedge aclk);
      s_axi_araddr <= {2'b00, idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         #1;
         if (s_axi_rvalid === 1'b1) begin
            rd_data = s_axi_rdata;
            rd_resp = s_axi_rresp;
            @(posedge aclk);
            s_axi_rready <= 1'b0;
            break;
         end
         ar_hs = s_axi_arvalid && s_axi_arready;
         @(posedge aclk);
         if (ar_hs) s_axi_arvalid <= 1'b0;
      end
   endtask : axi_read

   task automatic chk_rd(input logic [11:0] idx, input logic [31:0] exp);
      axi_read(idx);
      `CHECK("read data", exp, rd_data)
      `CHECK("read resp", mac_stats_pkg::RESP_OKAY, rd_resp)
   endtask : chk_rd

   // Increment pulse stands in the cycle after the report and is gone one cycle later
   task automatic send_ev(input bit rx, input logic crc, input logic [15:0] len,
                          input logic inj, input logic [3:0] exp);
      logic [3:0] a, b;
      @(posedge aclk);
      if (rx) rx_event <= '{1'b1, crc, len};
      else tx_event <= '{1'b1, crc, len};
      tx_error_inject <= inj;
      @(posedge aclk);
      tx_event <= '0;
      rx_event <= '0;
      tx_error_inject <= 1'b0;
      #1 a = rx ? rx_stats_inc : tx_stats_inc;
      @(posedge aclk);
      #1 b = rx ? rx_stats_inc : tx_stats_inc;
      `CHECK("inc vector", exp, a)
      `CHECK("inc pulse", 4'h0, b)
   endtask : send_ev

   //--------------------------------------------------------------------------
   // Scenarios
   //--------------------------------------------------------------------------
   task automatic t_reset;
      chk_rd(mac_stats_pkg::TX_STATS_STATUS_IDX, 32'h0000_0000);
      chk_rd(mac_stats_pkg::RX_STATS_STATUS_IDX, 32'h0000_0000);
      chk_rd(TX64, 32'h0000_0000);
      chk_rd(RX64, 32'h0000_0000);
      // Clear both sides once before trusting any count
      axi_write(mac_stats_pkg::TX_STATS_CONFIG_IDX, 32'h0000_0001);
      axi_write(mac_stats_pkg::TX_STATS_CONFIG_IDX, 32'h0000_0000);
      axi_write(mac_stats_pkg::RX_STATS_CONFIG_IDX, 32'h0000_0001);
      axi_write(mac_stats_pkg::RX_STATS_CONFIG_IDX, 32'h0000_0000);
   endtask : t_reset

   task automatic t_classify;
      send_ev(1'b0, 1'b0, 16'h0040, 1'b0, 4'h4);
      send_ev(1'b0, 1'b0, 16'h0041, 1'b0, 4'h8);
      send_ev(1'b0, 1'b0, 16'h007f, 1'b0, 4'h8);
      send_ev(1'b0, 1'b0, 16'h0080, 1'b0, 4'h0);
      send_ev(1'b0, 1'b1, 16'h003f, 1'b0, 4'h1);
      send_ev(1'b0, 1'b1, 16'h00c8, 1'b0, 4'h2);
      send_ev(1'b1, 1'b0, 16'h0040, 1'b0, 4'h4);
      chk_rd(TX64, 32'h0000_0001);
      `CHECK("disabled counter", 32'h0000_0000, off_rdata)
      chk_rd(TX64, 32'h0000_0001);
      chk_rd(TX64 + 12'h001, 32'h0000_0000);
      chk_rd(TX65, 32'h0000_0002);
      chk_rd(TXFR, 32'h0000_0001);
      chk_rd(TXCE, 32'h0000_0001);
      chk_rd(RX64, 32'h0000_0001);
   endtask : t_classify

   task automatic t_inject;
      send_ev(1'b0, 1'b0, 16'h0040, 1'b1, 4'h0);
      chk_rd(TX64, 32'h0000_0001);
   endtask : t_inject

   task automatic t_snapshot;
      axi_write(mac_stats_pkg::TX_STATS_CONFIG_IDX, 32'h0000_0004);
      `CHECK("cfg write resp", mac_stats_pkg::RESP_OKAY, wr_resp)
      chk_rd(mac_stats_pkg::TX_STATS_CONFIG_IDX, 32'h0000_0004);
      chk_rd(mac_stats_pkg::TX_STATS_STATUS_IDX, 32'h0000_0002);
      send_ev(1'b0, 1'b0, 16'h0040, 1'b0, 4'h4);
      send_ev(1'b0, 1'b0, 16'h0040, 1'b0, 4'h4);
      chk_rd(TX64, 32'h0000_0001);
      axi_write(mac_stats_pkg::TX_STATS_CONFIG_IDX, 32'h0000_0000);
      chk_rd(mac_stats_pkg::TX_STATS_STATUS_IDX, 32'h0000_0000);
      chk_rd(TX64, 32'h0000_0003);
      axi_write(mac_stats_pkg::RX_STATS_CONFIG_IDX, 32'h0000_0004);
      chk_rd(mac_stats_pkg::RX_STATS_STATUS_IDX, 32'h0000_0002);
      send_ev(1'b1, 1'b0, 16'h0040, 1'b0, 4'h4);
      chk_rd(RX64, 32'h0000_0001);
      axi_write(mac_stats_pkg::RX_STATS_CONFIG_IDX, 32'h0000_0000);
      chk_rd(mac_stats_pkg::RX_STATS_STATUS_IDX, 32'h0000_0000);
      chk_rd(RX64, 32'h0000_0002);
   endtask : t_snapshot

   task automatic t_clear;
      axi_write(mac_stats_pkg::TX_STATS_CONFIG_IDX, 32'h0000_0004);
      axi_write(mac_stats_pkg::TX_STATS_CONFIG_IDX, 32'h0000_0005);
      chk_rd(TX64, 32'h0000_0000);
      chk_rd(TX65, 32'h0000_0000);
      chk_rd(RX64, 32'h0000_0002);
      axi_write(mac_stats_pkg::TX_STATS_CONFIG_IDX, 32'h0000_0000);
      chk_rd(TXCE, 32'h0000_0000);
      axi_write(mac_stats_pkg::RX_STATS_CONFIG_IDX, 32'h0000_0001);
      axi_write(mac_stats_pkg::RX_STATS_CONFIG_IDX, 32'h0000_0000);
      chk_rd(RX64, 32'h0000_0000);
      send_ev(1'b1, 1'b0, 16'h0040, 1'b0, 4'h4);
      chk_rd(RX64, 32'h0000_0001);
   endtask : t_clear

   // Reset in mid-run must clear counters that hold a count
   task automatic t_rereset;
      send_ev(1'b0, 1'b0, 16'h0040, 1'b0, 4'h4);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      chk_rd(TX64, 32'h0000_0000);
      chk_rd(RX64, 32'h0000_0000);
   endtask : t_rereset

   task automatic t_unmapped;
      axi_read(12'h700);
      `CHECK("unmapped read", mac_stats_pkg::RESP_SLVERR, rd_resp)
      axi_write(12'h700, 32'h0000_0001);
      `CHECK("unmapped write", mac_stats_pkg::RESP_SLVERR, wr_resp)
      axi_write(mac_stats_pkg::RX_STATS_STATUS_IDX, 32'hffff_ffff);
      `CHECK("status write resp", mac_stats_pkg::RESP_OKAY, wr_resp)
      chk_rd(mac_stats_pkg::RX_STATS_STATUS_IDX, 32'h0000_0000);
   endtask : t_unmapped

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : final_report

   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_classify();
      t_inject();
      t_snapshot();
      t_clear();
      t_rereset();
      t_unmapped();
      final_report();
   end

   // Whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge aclk);
      n_errors++;
      final_report();
   end
endmodule : testbench

// file: design/mac_statistics_counters.sv
// MAC transmit and receive statistics counters with AXI4-Lite register access
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
module mac_statistics_counters #(
   parameter bit stats_enable = 1'b1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [15:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [15:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire mac_stats_pkg::stats_event_s tx_event,
   input wire logic tx_error_inject,
   input wire mac_stats_pkg::stats_event_s rx_event,
   output logic [3:0] tx_stats_inc,
   output logic [3:0] rx_stats_inc
);

   //--------------------------------------------------------------------------
   // Helpers
   //--------------------------------------------------------------------------
   function automatic logic [3:0] classify(input mac_stats_pkg::stats_event_s ev);
      logic short_frame;
      short_frame = ev.len < mac_stats_pkg::MIN_FRAME_LEN;
      classify[0] = ev.frame_end && ev.crc_err && short_frame;
      classify[1] = ev.frame_end && ev.crc_err && !short_frame;
      classify[2] = ev.frame_end && (ev.len == mac_stats_pkg::MIN_FRAME_LEN);
      classify[3] = ev.frame_end && !short_frame && (ev.len != mac_stats_pkg::MIN_FRAME_LEN)
                    && (ev.len <= mac_stats_pkg::SIZE_127_LEN);
   endfunction : classify

   function automatic logic [11:0] cnt_index(input int side, input int k);
      logic [11:0] base;
      logic [11:0] off;
      base = (side == 0) ? mac_stats_pkg::TX_CNT_BASE_IDX : mac_stats_pkg::RX_CNT_BASE_IDX;
      case (k)
         0: off = mac_stats_pkg::CNT_FRAG_OFF;
         1: off = mac_stats_pkg::CNT_CRCERR_OFF;
         2: off = mac_stats_pkg::CNT_64B_OFF;
         default: off = mac_stats_pkg::CNT_65TO127B_OFF;
      endcase
      cnt_index = base + off;
   endfunction : cnt_index

   //--------------------------------------------------------------------------
   // State
   //--------------------------------------------------------------------------
   logic [2:0] cfg [2];
   logic grant [2];
   logic [63:0] live [2][mac_stats_pkg::NUM_CNT];
   logic [63:0] shadow [2][mac_stats_pkg::NUM_CNT];
   logic [3:0] inc [2];
   logic aw_held;
   logic w_held;
   logic [11:0] aw_idx;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic [31:0] next_rdata;
   logic next_rerr;
   logic wr_fire;
   logic wr_mapped;
   logic [11:0] ar_idx;

   assign inc[0] = tx_stats_inc;
   assign inc[1] = rx_stats_inc;
   assign ar_idx = s_axi_araddr[13:2];
   assign wr_fire = aw_held && w_held && !s_axi_bvalid;

   //--------------------------------------------------------------------------
   // Increment vectors
   //--------------------------------------------------------------------------
   // Client increment vectors
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_stats_inc <= 4'h0;
         rx_stats_inc <= 4'h0;
      end else if (ce) begin
         tx_stats_inc <= tx_error_inject ? 4'h0 : classify(tx_event);
         rx_stats_inc <= classify(rx_event);
      end
   end

   //--------------------------------------------------------------------------
   // Live counters
   //--------------------------------------------------------------------------
   // Wrapping instead of saturating keeps the adder a plain carry chain
   always_ff @(posedge aclk) begin
      for (int s = 0; s < 2; s++) begin
         for (int k = 0; k < mac_stats_pkg::NUM_CNT; k++) begin
            if (!aresetn) begin
               live[s][k] <= mac_stats_pkg::CNT_RESET;
            end else if (ce) begin
               if (!stats_enable) begin
                  live[s][k] <= mac_stats_pkg::CNT_RESET;
               end else if (cfg[s][mac_stats_pkg::CFG_CLEAR_BIT]) begin
                  live[s][k] <= mac_stats_pkg::CNT_RESET;
               end else if (inc[s][k]) begin
                  live[s][k] <= live[s][k] + 64'h0000_0000_0000_0001;
               end
            end
         end
      end
   end

   //--------------------------------------------------------------------------
   // Snapshot
   //--------------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      for (int s = 0; s < 2; s++) begin
         if (!aresetn) begin
            grant[s] <= 1'b0;
         end else if (ce) begin
            grant[s] <= cfg[s][mac_stats_pkg::CFG_SHADOW_BIT];
         end
      end
   end

   always_ff @(posedge aclk) begin
      for (int s = 0; s < 2; s++) begin
         for (int k = 0; k < mac_stats_pkg::NUM_CNT; k++) begin
            if (!aresetn) begin
               shadow[s][k] <= mac_stats_pkg::CNT_RESET;
            end else if (ce) begin
               if (cfg[s][mac_stats_pkg::CFG_CLEAR_BIT] || !stats_enable) begin
                  shadow[s][k] <= mac_stats_pkg::CNT_RESET;
               end else if (cfg[s][mac_stats_pkg::CFG_SHADOW_BIT] && !grant[s]) begin
                  shadow[s][k] <= live[s][k];
               end
            end
         end
      end
   end

   //--------------------------------------------------------------------------
   // AXI4-Lite write channel
   //--------------------------------------------------------------------------
   always_comb begin
      wr_mapped = (aw_idx == mac_stats_pkg::TX_STATS_CONFIG_IDX)
                  || (aw_idx == mac_stats_pkg::RX_STATS_CONFIG_IDX)
                  || (aw_idx == mac_stats_pkg::TX_STATS_STATUS_IDX)
                  || (aw_idx == mac_stats_pkg::RX_STATS_STATUS_IDX);
      for (int s = 0; s < 2; s++) begin
         for (int k = 0; k < mac_stats_pkg::NUM_CNT; k++) begin
            if (aw_idx == cnt_index(s, k) || aw_idx == cnt_index(s, k) + 12'h001) begin
               wr_mapped = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         aw_held <= 1'b0;
         aw_idx <= 12'h000;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_idx <= s_axi_awaddr[13:2];
            s_axi_awready <= 1'b0;
         end else if (wr_fire) begin
            aw_held <= 1'b0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_wready <= 1'b1;
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (ce) begin
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end else if (wr_fire) begin
            w_held <= 1'b0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= mac_stats_pkg::RESP_OKAY;
      end else if (ce) begin
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? mac_stats_pkg::RESP_OKAY : mac_stats_pkg::RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Only byte lane 0 carries the writable bits; other lanes are ignored
   always_ff @(posedge aclk) begin
      for (int s = 0; s < 2; s++) begin
         if (!aresetn) begin
            cfg[s] <= mac_stats_pkg::CFG_RESET;
         end else if (ce && wr_fire && w_strb[0]) begin
            if (aw_idx == ((s == 0) ? mac_stats_pkg::TX_STATS_CONFIG_IDX
                                    : mac_stats_pkg::RX_STATS_CONFIG_IDX)) begin
               cfg[s] <= {w_data[mac_stats_pkg::CFG_SHADOW_BIT], 1'b0,
                          w_data[mac_stats_pkg::CFG_CLEAR_BIT]};
            end
         end
      end
   end

   //--------------------------------------------------------------------------
   // AXI4-Lite read channel
   //--------------------------------------------------------------------------
   always_comb begin
      next_rdata = 32'h0000_0000;
      next_rerr = 1'b1;
      for (int s = 0; s < 2; s++) begin
         if (ar_idx == ((s == 0) ? mac_stats_pkg::TX_STATS_CONFIG_IDX
                                 : mac_stats_pkg::RX_STATS_CONFIG_IDX)) begin
            next_rdata[2:0] = cfg[s];
            next_rerr = 1'b0;
         end
         if (ar_idx == ((s == 0) ? mac_stats_pkg::TX_STATS_STATUS_IDX
                                 : mac_stats_pkg::RX_STATS_STATUS_IDX)) begin
            next_rdata[mac_stats_pkg::STS_GRANT_BIT] = grant[s];
            next_rerr = 1'b0;
         end
         for (int k = 0; k < mac_stats_pkg::NUM_CNT; k++) begin
            if (ar_idx == cnt_index(s, k)) begin
               next_rdata = grant[s] ? shadow[s][k][31:0] : live[s][k][31:0];
               next_rerr = 1'b0;
            end
            if (ar_idx == cnt_index(s, k) + 12'h001) begin
               next_rdata = grant[s] ? shadow[s][k][63:32] : live[s][k][63:32];
               next_rerr = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= mac_stats_pkg::RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rerr ? mac_stats_pkg::RESP_SLVERR : mac_stats_pkg::RESP_OKAY;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   //--------------------------------------------------------------------------
   // Assertions
   //--------------------------------------------------------------------------
   sequence tx_clear_held;
      ce && cfg[0][mac_stats_pkg::CFG_CLEAR_BIT] ##1 ce;
   endsequence

   sequence rx_clear_held;
      ce && cfg[1][mac_stats_pkg::CFG_CLEAR_BIT] ##1 ce;
   endsequence

   wrap_to_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && stats_enable && !cfg[1][mac_stats_pkg::CFG_CLEAR_BIT] && rx_stats_inc[2]
       && live[1][2] == 64'hffff_ffff_ffff_ffff) |=> (live[1][2] == 64'h0000_0000_0000_0000))
      else $error("counter did not wrap to zero");

   size_class_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && rx_event.frame_end && !rx_event.crc_err && rx_event.len == 16'h0040)
      |=> rx_stats_inc == 4'h4)
      else $error("64 byte frame misclassified");

   disabled_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && !stats_enable) |=> live[0][1] == 64'h0000_0000_0000_0000)
      else $error("counter moved with statistics disabled");

   reset_zero_a: assert property (@(posedge aclk)
      (ce && !aresetn) |=> (live[0][0] == 64'h0000_0000_0000_0000
                      && live[1][3] == 64'h0000_0000_0000_0000))
      else $error("reset did not clear counters");

   tx_clear_all_a: assert property (@(posedge aclk) disable iff (!aresetn)
      tx_clear_held |-> (live[0][0] == 64'h0000_0000_0000_0000
                         && live[0][3] == 64'h0000_0000_0000_0000))
      else $error("transmit clear incomplete");

   rx_clear_all_a: assert property (@(posedge aclk) disable iff (!aresetn)
      rx_clear_held |-> (live[1][1] == 64'h0000_0000_0000_0000
                         && shadow[1][2] == 64'h0000_0000_0000_0000))
      else $error("receive clear incomplete");

   inc_vector_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && stats_enable && !cfg[0][mac_stats_pkg::CFG_CLEAR_BIT] && tx_stats_inc[1])
      |=> live[0][1] == $past(live[0][1]) + 64'h0000_0000_0000_0001)
      else $error("increment vector not counted");

   read_keeps_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && s_axi_arvalid && s_axi_arready && rx_stats_inc == 4'h0
       && !cfg[1][mac_stats_pkg::CFG_CLEAR_BIT]) |=> $stable(live[1][0]))
      else $error("read changed a counter");

   snapshot_frozen_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && grant[0] && cfg[0][mac_stats_pkg::CFG_SHADOW_BIT]
       && !cfg[0][mac_stats_pkg::CFG_CLEAR_BIT]) |=> $stable(shadow[0][1]))
      else $error("snapshot moved while granted");

   grant_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && $changed(cfg[1][mac_stats_pkg::CFG_SHADOW_BIT])) ##1 ce
      |-> grant[1] == $past(cfg[1][mac_stats_pkg::CFG_SHADOW_BIT]))
      else $error("grant did not follow request");

   inject_mask_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && tx_error_inject) |=> tx_stats_inc == 4'h0)
      else $error("injected error was counted");

   clear_shadow_a: assert property (@(posedge aclk) disable iff (!aresetn)
      tx_clear_held |-> shadow[0][0] == 64'h0000_0000_0000_0000)
      else $error("clear left snapshot data");

endmodule : mac_statistics_counters

// file: design/mac_stats_pkg.sv
// Shared constants, register map and event carrier of the MAC statistics counters
//--------------------------------------------------------------------------
//--------------------------------------------------------------------------
package mac_stats_pkg;

   //--------------------------------------------------------------------------
   // Register indices (byte address is four times the index)
   //--------------------------------------------------------------------------
   localparam logic [11:0] TX_STATS_CONFIG_IDX = 12'h845;
   localparam logic [11:0] TX_STATS_STATUS_IDX = 12'h846;
   localparam logic [11:0] RX_STATS_CONFIG_IDX = 12'h945;
   localparam logic [11:0] RX_STATS_STATUS_IDX = 12'h946;
   localparam logic [11:0] TX_CNT_BASE_IDX = 12'h800;
   localparam logic [11:0] RX_CNT_BASE_IDX = 12'h900;
   // Counter slots: fragments, CRC errors, 64 byte, 65 to 127 byte
   localparam logic [11:0] CNT_FRAG_OFF = 12'h000;
   localparam logic [11:0] CNT_CRCERR_OFF = 12'h006;
   localparam logic [11:0] CNT_64B_OFF = 12'h016;
   localparam logic [11:0] CNT_65TO127B_OFF = 12'h018;
   localparam int NUM_CNT = 4;

   //--------------------------------------------------------------------------
   // Fields and reset values
   //--------------------------------------------------------------------------
   localparam int CFG_CLEAR_BIT = 0;
   localparam int CFG_SHADOW_BIT = 2;
   localparam int STS_GRANT_BIT = 1;
   localparam logic [2:0] CFG_RESET = 3'h0;
   localparam logic [63:0] CNT_RESET = 64'h0000_0000_0000_0000;
   localparam logic [15:0] MIN_FRAME_LEN = 16'h0040;
   localparam logic [15:0] SIZE_127_LEN = 16'h007f;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // One frame report from the datapath, length already covers DA, SA, data and CRC
   typedef struct packed {
      logic frame_end;
      logic crc_err;
      logic [15:0] len;
   } stats_event_s;

endpackage : mac_stats_pkg
